// ### add_carry_branch_link_exec.sv
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "exec_defines.svh"
module add_carry_branch_link_exec (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic mem_req,
	output logic mem_write,
	output exec_pkg::word_t mem_addr,
	output exec_pkg::word_t mem_wdata,
	input exec_pkg::word_t mem_rdata,
	input wire logic mem_ack,
	input wire logic mem_err
);
	import exec_pkg::*;

	regs_t s;
	regs_t n;
	word_t iw;
	word_t add_a;
	word_t add_b;
	word_t sum;
	word_t ea;
	word_t base;
	logic add_c;
	logic add_co;
	logic add_v;
	logic [4:0] f_op;
	logic [2:0] f_r1;
	logic [2:0] f_r2;
	logic [1:0] f_rb;
	logic [1:0] f_am;
	logic is_add_word_carry_in;
	logic is_awi_reg;
	logic is_br;
	logic is_bal;
	logic is_awi_stg;
	logic is_branch_link_short;
	logic ahb_go;
	logic busy;
	logic ok;

	function automatic ind_t result_flags(input word_t r, input logic c,
		input logic v);
		ind_t f;
		f.even = ~r[0];
		f.carry = c;
		f.ovf = v;
		f.neg = r[15];
		f.zero = (r == 16'h0000);
		return f;
	endfunction

	// During fetch the instruction is decoded straight from the bus so the
	// register form of add-with-carry finishes in a single access.
	assign iw = (s.st == ST_FETCH) ? mem_rdata : s.instr;
	assign f_op = iw[15:11];
	assign f_r1 = iw[10:8];
	assign f_r2 = iw[7:5];
	assign f_rb = iw[7:6];
	assign f_am = iw[5:4];
	assign is_add_word_carry_in = (f_op == `OP_RR) && (iw[4:0] == `FN_ADD_WORD_CARRY_IN);
	assign is_awi_reg = (f_op == `OP_RR) && (iw[4:0] == `FN_AWI_REG);
	assign is_bal = (f_op == `OP_BRANCH) && (iw[3:0] == `FN_BAL);
	assign is_br = is_bal || ((f_op == `OP_BRANCH) && (iw[3:0] == `FN_B));
	assign is_awi_stg = (f_op == `OP_AWI_STG) && (iw[3:0] == `FN_AWI_STG);
	assign is_branch_link_short = (f_op == `OP_BRANCH_LINK_SHORT);
	assign ahb_go = hsel && htrans[1] && hready;
	assign busy = (s.st != ST_IDLE);
	assign ok = mem_ack && !mem_err;

	always_comb begin
		case (s.st)
			ST_FETCH: begin
				add_a = s.gpr[f_r1];
				add_b = s.gpr[f_r2];
				add_c = s.ind.carry;
			end
			ST_EXT1: begin
				add_a = s.gpr[f_r1];
				add_b = mem_rdata;
				add_c = 1'b0;
			end
			default: begin
				add_a = mem_rdata;
				add_b = s.w1;
				add_c = 1'b0;
			end
		endcase
	end

	exec_add16 u_add (
		.a(add_a),
		.b(add_b),
		.cin(add_c),
		.sum(sum),
		.carry(add_co),
		.ovf(add_v)
	);

	always_comb begin
		n = s;
		ea = 16'h0000;
		base = (f_r2 != 3'h0) ? s.gpr[f_r2] : 16'h0000;
		n.hwr = ahb_go && hwrite;
		n.haddr = haddr[7:0];
		if (ahb_go && !hwrite) begin
			n.hrdata = 32'h0000_0000;
			case (haddr[7:0])
				`OFF_CTRL: n.hrdata[`CTRL_STEP] = busy;
				`OFF_IAR: n.hrdata[15:0] = s.iar;
				`OFF_STATUS: begin
					n.hrdata[4:0] = s.ind;
					n.hrdata[`STAT_SPEC] = s.spec;
					n.hrdata[`STAT_INVAL] = s.inval;
					n.hrdata[`STAT_BUSY] = busy;
				end
				default: begin
					if (haddr[7:5] == `GPR_BANK) begin
						n.hrdata[15:0] = s.gpr[haddr[4:2]];
					end
				end
			endcase
		end
		// Software writes are dropped while a step runs, so the machine never
		// races a register update against its own result.
		if (s.hwr && !busy) begin
			case (s.haddr)
				`OFF_CTRL: begin
					if (hwdata[`CTRL_STEP]) begin
						n.st = ST_FETCH;
						n.req = 1'b1;
						n.we = 1'b0;
						n.ma = s.iar;
						n.spec = 1'b0;
						n.inval = 1'b0;
					end
				end
				`OFF_IAR: n.iar = hwdata[15:0];
				`OFF_STATUS: n.ind = hwdata[4:0];
				default: begin
					if (s.haddr[7:5] == `GPR_BANK) begin
						n.gpr[s.haddr[4:2]] = hwdata[15:0];
					end
				end
			endcase
		end
		case (s.st)
			ST_IDLE: begin
			end
			ST_FETCH: begin
				if (mem_ack) begin
					n.req = 1'b0;
					n.st = ST_IDLE;
					if (mem_err) begin
						n.inval = 1'b1;
					end else begin
						n.instr = mem_rdata;
						n.iar = s.iar + `WORD_STEP;
						if (is_add_word_carry_in) begin
							n.gpr[f_r2] = sum;
							n.ind = result_flags(sum, add_co, add_v);
							n.ind.even = s.ind.even;
							n.ind.zero = s.ind.zero && (sum == 16'h0000);
						end else if (is_awi_reg || is_br || is_awi_stg) begin
							n.st = ST_EXT1;
							n.req = 1'b1;
							n.ma = s.iar + `WORD_STEP;
						end else if (is_branch_link_short) begin
							// The base is read before the link lands in register 7.
							ea = s.gpr[f_r1] + {{7{iw[7]}}, iw[7:0], 1'b0};
							n.gpr[`LINK_SHORT] = s.iar + `WORD_STEP;
							if (ea[0]) begin
								n.spec = 1'b1;
							end else begin
								n.st = ST_IND;
								n.req = 1'b1;
								n.ma = ea;
							end
						end
					end
				end
			end
			ST_EXT1: begin
				if (mem_ack) begin
					n.req = 1'b0;
					n.st = ST_IDLE;
					if (mem_err) begin
						n.inval = 1'b1;
					end else begin
						n.w1 = mem_rdata;
						n.iar = s.iar + `WORD_STEP;
						if (is_awi_reg) begin
							n.gpr[f_r2] = sum;
							n.ind = result_flags(sum, add_co, add_v);
						end else if (is_br) begin
							ea = mem_rdata + base;
							if (is_bal) begin
								n.gpr[f_r1] = s.iar + `WORD_STEP;
							end
							if (ea[0]) begin
								n.spec = 1'b1;
							end else if (s.instr[4]) begin
								n.st = ST_IND;
								n.req = 1'b1;
								n.ma = ea;
							end else begin
								n.iar = ea;
							end
						end else if (f_am[1]) begin
							n.st = ST_EXT2;
							n.req = 1'b1;
							n.ma = s.iar + `WORD_STEP;
						end else if (s.gpr[f_rb][0]) begin
							n.spec = 1'b1;
						end else begin
							n.st = ST_OPRD;
							n.req = 1'b1;
							n.ma = s.gpr[f_rb];
						end
					end
				end
			end
			ST_EXT2: begin
				if (mem_ack) begin
					n.req = 1'b0;
					n.st = ST_IDLE;
					if (mem_err) begin
						n.inval = 1'b1;
					end else begin
						n.iar = s.iar + `WORD_STEP;
						ea = s.gpr[f_rb] + mem_rdata;
						if (ea[0]) begin
							n.spec = 1'b1;
						end else begin
							n.st = f_am[0] ? ST_IND : ST_OPRD;
							n.req = 1'b1;
							n.ma = ea;
						end
					end
				end
			end
			ST_IND: begin
				if (mem_ack) begin
					n.req = 1'b0;
					n.st = ST_IDLE;
					if (mem_err) begin
						n.inval = 1'b1;
					end else if (mem_rdata[0]) begin
						n.spec = 1'b1;
					end else if (is_awi_stg) begin
						n.st = ST_OPRD;
						n.req = 1'b1;
						n.ma = mem_rdata;
					end else begin
						n.iar = mem_rdata;
					end
				end
			end
			ST_OPRD: begin
				if (mem_ack) begin
					if (mem_err) begin
						n.req = 1'b0;
						n.st = ST_IDLE;
						n.inval = 1'b1;
					end else begin
						n.st = ST_OPWR;
						n.we = 1'b1;
						n.wdata = sum;
						n.pend = result_flags(sum, add_co, add_v);
					end
				end
			end
			ST_OPWR: begin
				if (mem_ack) begin
					n.req = 1'b0;
					n.we = 1'b0;
					n.st = ST_IDLE;
					if (mem_err) begin
						n.inval = 1'b1;
					end else begin
						n.ind = s.pend;
					end
				end
			end
			default: begin
				n.st = ST_IDLE;
				n.req = 1'b0;
				n.we = 1'b0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.iar <= `RST_IAR;
			s.ind <= `RST_IND;
		end else begin
			s <= n;
		end
	end

	assign hrdata = s.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign mem_req = s.req;
	assign mem_write = s.we;
	assign mem_addr = s.ma;
	assign mem_wdata = s.wdata;

	// Reference sum built apart from the adder, so a slip there shows up.
	logic [16:0] chk_full;
	word_t chk_lo;
	logic chk_c;
	logic fetch_ok;
	logic ext_ok;
	assign chk_full = {1'b0, s.gpr[f_r1]} + {1'b0, s.gpr[f_r2]}
		+ {16'h0000, s.ind.carry};
	assign chk_lo = chk_full[15:0];
	assign chk_c = chk_full[16];
	assign fetch_ok = (s.st == ST_FETCH) && ok;
	assign ext_ok = (s.st == ST_EXT1) && ok;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	add_word_carry_in_result_a: assert property (fetch_ok && is_add_word_carry_in |=>
		s.gpr[$past(f_r2)] == $past(chk_lo))
		else $error("add-with-carry result wrong");
	add_word_carry_in_carry_a: assert property (fetch_ok && is_add_word_carry_in |=>
		s.ind.carry == $past(chk_c))
		else $error("add-with-carry carry wrong");
	ovf_sign_a: assert property ((fetch_ok && is_add_word_carry_in || ext_ok &&
		is_awi_reg) && add_v |=> s.ind.ovf && (s.ind.carry != s.ind.neg))
		else $error("overflow sign not in carry");
	add_word_carry_in_flags_a: assert property (fetch_ok && is_add_word_carry_in && !s.ind.zero
		|=> !s.ind.zero && $stable(s.ind.even))
		else $error("add-with-carry even or zero wrong");
	add_word_carry_in_nocheck_a: assert property (fetch_ok && is_add_word_carry_in |=>
		!s.spec && !s.inval && !busy)
		else $error("add-with-carry raised a check");
	stg_write_a: assert property ((s.st == ST_OPRD) && ok |=>
		mem_req && mem_write && $stable(mem_addr) && mem_wdata == $past(sum))
		else $error("storage add write-back wrong");
	bal_link_a: assert property (ext_ok && is_bal |=>
		s.gpr[$past(f_r1)] == $past(s.iar) + `WORD_STEP)
		else $error("link register not written");
	branch_link_short_link_a: assert property (fetch_ok && is_branch_link_short |=>
		s.gpr[`LINK_SHORT] == $past(s.iar) + `WORD_STEP)
		else $error("short link not in register 7");
	br_ind_a: assert property (busy && (is_br || is_branch_link_short) |=>
		$stable(s.ind))
		else $error("branch changed indicators");
	tgt_load_a: assert property ((s.st == ST_IND) && ok && !is_awi_stg
		&& !mem_rdata[0] |=> s.iar == $past(mem_rdata) && !busy)
		else $error("indirect target not loaded");
	odd_tgt_a: assert property ((s.st == ST_IND) && ok && mem_rdata[0]
		|=> s.spec && $stable(s.iar))
		else $error("odd target not checked");

	add_word_carry_in_c: cover property (fetch_ok && is_add_word_carry_in && s.ind.carry);
	bal_ind_c: cover property (ext_ok && is_bal && s.instr[4] ##[1:40]
		(s.st == ST_IND) && ok);
	stg_c: cover property ((s.st == ST_OPWR) && ok);
	spec_c: cover property (busy ##1 s.spec);

endmodule

// ### exec_add16.sv
`timescale 1ns/1ps
module exec_add16 (
	input exec_pkg::word_t a,
	input exec_pkg::word_t b,
	input wire logic cin,
	output exec_pkg::word_t sum,
	output logic carry,
	output logic ovf
);
	import exec_pkg::*;

	logic [16:0] full;

	assign full = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
	assign sum = full[15:0];
	// When the sum overflows, both operands share a sign, so the carry out
	// equals the true sign of the full sum.
	assign carry = full[16];
	assign ovf = (a[15] == b[15]) && (sum[15] != a[15]);

endmodule

// ### exec_defines.svh
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// Register byte offsets on the bus, low eight address bits decoded.
`define OFF_CTRL 8'h00
`define OFF_IAR 8'h04
`define OFF_STATUS 8'h08
`define GPR_BANK 3'h1

// Field positions.
`define CTRL_STEP 0
`define STAT_SPEC 8
`define STAT_INVAL 9
`define STAT_BUSY 16

// Reset values.
`define RST_IAR 16'h0000
`define RST_IND 5'h00

// Instruction encodings.
`define OP_RR 5'h0e
`define FN_ADD_WORD_CARRY_IN 5'h09
`define FN_AWI_REG 5'h01
`define OP_AWI_STG 5'h08
`define FN_AWI_STG 4'h9
`define OP_BRANCH 5'h0c
`define FN_B 4'h0
`define FN_BAL 4'h1
`define OP_BRANCH_LINK_SHORT 5'h1f
`define LINK_SHORT 3'h7
`define WORD_STEP 16'h0002

`endif

// ### exec_pkg.sv
package exec_pkg;

	typedef logic [15:0] word_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_FETCH = 7'h02,
		ST_EXT1 = 7'h04,
		ST_EXT2 = 7'h08,
		ST_IND = 7'h10,
		ST_OPRD = 7'h20,
		ST_OPWR = 7'h40
	} state_t;

	typedef struct packed {
		logic even;
		logic carry;
		logic ovf;
		logic neg;
		logic zero;
	} ind_t;

	typedef struct packed {
		state_t st;
		logic [7:0][15:0] gpr;
		word_t iar;
		word_t instr;
		word_t w1;
		word_t ma;
		word_t wdata;
		ind_t ind;
		ind_t pend;
		logic req;
		logic we;
		logic spec;
		logic inval;
		logic hwr;
		logic [7:0] haddr;
		logic [31:0] hrdata;
	} regs_t;

endpackage

// ### storage_model.sv
`timescale 1ns/1ps
module storage_model import exec_pkg::*; #(
	parameter logic [15:0] BAD_BASE = 16'hf000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic mem_req,
	input wire logic mem_write,
	input exec_pkg::word_t mem_addr,
	input exec_pkg::word_t mem_wdata,
	output exec_pkg::word_t mem_rdata,
	output logic mem_ack,
	output logic mem_err
);
	word_t mem [32768];
	logic [3:0] lat;
	logic [3:0] cnt;
	logic bad;
	assign bad = mem_addr >= BAD_BASE;
	// Outside an ack the read bus toggles, so a stale sample never matches.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 16'h0000;
			cnt <= 4'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				if (cnt >= lat) begin
					cnt <= 4'h0;
					mem_ack <= 1'b1;
					mem_err <= bad;
					if (!bad && mem_write)
						mem[mem_addr[15:1]] <= mem_wdata;
					else if (!bad)
						mem_rdata <= mem[mem_addr[15:1]];
				end else
					cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

// ### tb.sv
`timescale 1ns/1ps
`define CHECK(g, e) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("wrong value at %0t: got %h expected %h", $time, g, e); \
	end \
end
module tb;
	import exec_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, mem_req, mem_write, mem_ack, mem_err;
	word_t mem_addr, mem_wdata, mem_rdata;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	assign hready = hreadyout;
	add_carry_branch_link_exec add_carry_branch_link_exec_i (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .mem_req, .mem_write, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_ack, .mem_err);
	storage_model storage_model_i (.hclk, .hresetn, .mem_req, .mem_write,
		.mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .mem_err);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// The ceiling is far above the under one thousand cycles the tests need.
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [7:0] a, input word_t e);
		bus(1'b0, a, 32'h0000_0000);
		`CHECK(rd, {16'h0000, e})
	endtask
	function automatic logic [7:0] g(input int k);
		return 8'h20 + 8'(4 * k);
	endfunction
	task automatic wg(input int k, input word_t v);
		bus(1'b1, g(k), {16'h0000, v});
	endtask
	task automatic put(input word_t a, input word_t d);
		storage_model_i.mem[a[15:1]] = d;
	endtask
	task automatic step(input word_t iar, input logic [4:0] ind);
		bus(1'b1, 8'h04, {16'h0000, iar});
		bus(1'b1, 8'h08, {27'h000_0000, ind});
		bus(1'b1, 8'h00, 32'h0000_0001);
		for (int i = 0; i < 100; i++) begin
			bus(1'b0, 8'h00, 32'h0000_0000);
			if (rd[0] === 1'b0)
				break;
		end
	endtask
	task automatic add_word_carry_in(input int r1, input int r2, input word_t v1,
		input word_t v2, input logic [4:0] ind, input word_t res,
		input word_t st);
		wg(r2, v2);
		wg(r1, v1);
		put(16'h0100, {5'h0e, 3'(r1), 3'(r2), 5'h09});
		step(16'h0100, ind);
		chk(g(r2), res);
		if (r1 != r2)
			chk(g(r1), v1);
		chk(8'h08, st);
		chk(8'h04, 16'h0102);
		`CHECK(hresp, 1'b0)
		$display("add with carry test done");
	endtask
	task automatic air();
		wg(2, 16'hfffe);
		wg(5, 16'h1111);
		put(16'h0100, {5'h0e, 3'h2, 3'h5, 5'h01});
		put(16'h0102, 16'h0002);
		step(16'h0100, 5'h04);
		chk(g(5), 16'h0000);
		chk(g(2), 16'hfffe);
		chk(8'h08, 16'h0019);
		chk(8'h04, 16'h0104);
		$display("immediate register add test done");
	endtask
	task automatic sai();
		word_t ea;
		wg(1, 16'h0100);
		for (int am = 0; am < 4; am++) begin
			ea = am < 2 ? 16'h0100 : (am == 2 ? 16'h0120 : 16'h0140);
			storage_model_i.lat = 4'(am);
			put(16'h0200, {5'h08, 3'h0, 2'h1, 2'(am), 4'h9});
			put(16'h0202, 16'h7fff);
			put(16'h0204, 16'h0020);
			put(16'h0120, 16'h0140);
			put(ea, 16'h0001);
			step(16'h0200, 5'h00);
			`CHECK(storage_model_i.mem[ea[15:1]], 16'h8000)
			`CHECK(storage_model_i.mem[15'h0101], 16'h7fff)
			chk(8'h08, 16'h0016);
			chk(8'h04, am < 2 ? 16'h0204 : 16'h0206);
		end
		$display("storage immediate add test done");
	endtask
	task automatic sck();
		for (int i = 0; i < 2; i++) begin
			wg(1, i ? 16'hf000 : 16'h0101);
			put(16'h0200, {5'h08, 3'h0, 2'h1, 2'h0, 4'h9});
			put(16'h0100, 16'h1234);
			step(16'h0200, 5'h00);
			chk(8'h08, i ? 16'h0200 : 16'h0100);
			chk(8'h04, 16'h0204);
			`CHECK(storage_model_i.mem[15'h0080], 16'h1234)
		end
		step(16'hf000, 5'h00);
		chk(8'h08, 16'h0200);
		$display("storage check test done");
	endtask
	task automatic br(input int fn, input int r1, input int r2,
		input logic ind, input word_t aw, input word_t iar, input word_t st);
		put(16'h0300, {5'h0c, 3'(r1), 3'(r2), ind, 4'(fn)});
		put(16'h0302, aw);
		step(16'h0300, 5'h1f);
		chk(8'h04, iar);
		chk(8'h08, st);
		if (fn != 0)
			chk(g(r1), 16'h0304);
		else if (r2 != 0)
			chk(g(r2), 16'h0100);
		$display("branch test done");
	endtask
	task automatic branch_link_short(input int r, input word_t rv, input logic [7:0] disp,
		input word_t iar, input word_t st);
		wg(r, rv);
		put(16'h0500, {5'h1f, 3'(r), disp});
		put(16'h00fe, 16'h0700);
		step(16'h0500, 5'h1f);
		chk(8'h04, iar);
		chk(g(7), 16'h0502);
		chk(8'h08, st);
		$display("short link test done");
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		storage_model_i.lat = 4'h1;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(8'h04, 16'h0000);
		chk(8'h08, 16'h0000);
		bus(1'b1, 8'h10, 32'hffff_ffff);
		chk(8'h10, 16'h0000);
		$display("reset and map test done");
		add_word_carry_in(1, 2, 16'h7fff, 16'h0000, 5'h19, 16'h8000, 16'h0016);
		add_word_carry_in(3, 3, 16'h8000, 16'h8000, 5'h08, 16'h0001, 16'h000c);
		add_word_carry_in(4, 5, 16'h0001, 16'hffff, 5'h01, 16'h0000, 16'h0009);
		add_word_carry_in(4, 6, 16'h0001, 16'hffff, 5'h00, 16'h0000, 16'h0008);
		air();
		sai();
		sck();
		wg(0, 16'h5555);
		wg(2, 16'h0100);
		wg(3, 16'h0100);
		put(16'h0400, 16'h0600);
		put(16'h0402, 16'h0601);
		br(0, 0, 0, 1'b0, 16'h0400, 16'h0400, 16'h001f);
		br(0, 0, 2, 1'b1, 16'h0300, 16'h0600, 16'h001f);
		br(0, 0, 0, 1'b0, 16'h0401, 16'h0304, 16'h011f);
		br(1, 3, 3, 1'b0, 16'h0200, 16'h0300, 16'h001f);
		br(1, 4, 0, 1'b1, 16'hf000, 16'h0304, 16'h021f);
		br(1, 5, 0, 1'b1, 16'h0402, 16'h0304, 16'h011f);
		branch_link_short(7, 16'h0100, 8'hff, 16'h0700, 16'h001f);
		branch_link_short(2, 16'h0000, 8'h7f, 16'h0700, 16'h001f);
		branch_link_short(1, 16'h0101, 8'h01, 16'h0502, 16'h011f);
		branch_link_short(1, 16'hf000, 8'h00, 16'h0502, 16'h021f);
		tally_and_finish();
	end
endmodule
